// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic       clock_in, reset_in, write_in, read_in, start, use_osc, special, from_osc;
  logic [3:0] addr_in, mode_code;
  logic [7:0] wdata_in, rdata_out, pulses, seen, hold, latch;
  logic [1:0] pin_level, pin_out, pin_oe, rc;
  logic [4:0] route;
  logic       ext_pin, osc, busy, irq;
  logic [4:0] route_tab [4];
  int         errors, tests_run, cycles;

  tmc_timer dut (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .external_count_pin_in(ext_pin), .low_power_osc_in(osc), .pin_level_in(pin_level),
    .special_event_in(special), .compare_mode_code_in(mode_code),
    .system_clock_from_osc_in(from_osc), .pin_out(pin_out), .pin_oe_out(pin_oe),
    .ccp_timebase_out(route), .irq_out(irq));
  tmc_ext_source src (.clock_in(clock_in), .start_in(start), .pulses_in(pulses),
    .use_osc_in(use_osc), .count_pin_out(ext_pin), .osc_out(osc), .busy_out(busy));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Counts: errors %0d, tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Instruction phase at start and stop makes the count uncertain by one
  task automatic cmp_near(input string name, input int exp, input logic [7:0] got);
    tests_run++;
    if (!(got === 8'(exp) || got === 8'(exp + 1) || got === 8'(exp - 1))) begin
      errors++;
      $display("Error %s expected %0d seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 seen = rdata_out;
  endtask

  task automatic trigger(input logic [3:0] code, input logic with_write);
    @(posedge clock_in);
    mode_code <= code;
    special <= 1'b1;
    addr_in <= tmc_pkg::OFF_COUNT_LOW;
    wdata_in <= 8'h55;
    write_in <= with_write;
    @(posedge clock_in);
    special <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic burst(input logic [7:0] n);
    @(posedge clock_in);
    pulses <= n;
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    repeat (300) begin
      @(posedge clock_in);
      if (!busy) break;
    end
    repeat (12) @(posedge clock_in);
  endtask

  initial begin
    {write_in, read_in, start, use_osc, special, from_osc} = 6'h00;
    {addr_in, mode_code, wdata_in, pulses} = 24'h000000;
    route_tab = '{tmc_pkg::ROUTE_ALL_LOW, tmc_pkg::ROUTE_FROM_TWO,
                  tmc_pkg::ROUTE_FROM_THREE, tmc_pkg::ROUTE_ALL_HIGH};
    pin_level = 2'($urandom(32'hd419));
    reset_in = 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(tmc_pkg::OFF_CONTROL); cmp8("control", 8'h00, seen);
    rd(tmc_pkg::OFF_DIRECTION); cmp8("direction", 8'hFF, seen);
    rd(tmc_pkg::OFF_COUNT_LOW); cmp8("count low", 8'h00, seen);
    rd(4'h9); cmp8("unmapped", 8'h00, seen);
    wr(tmc_pkg::OFF_ENABLES, 8'h02);
    wr(tmc_pkg::OFF_COUNT_HIGH, 8'hFF);
    wr(tmc_pkg::OFF_COUNT_LOW, 8'hF0);
    wr(tmc_pkg::OFF_CONTROL, 8'h01);
    repeat (100) @(posedge clock_in);
    wr(tmc_pkg::OFF_CONTROL, 8'h00);
    rd(tmc_pkg::OFF_FLAGS); cmp8("flags", 8'h02, seen);
    rd(tmc_pkg::OFF_COUNT_HIGH); cmp8("count high", 8'h00, seen);
    cmp8("irq", 8'h01, {7'h00, irq});
    wr(tmc_pkg::OFF_ENABLES, 8'h00);
    #1 cmp8("irq masked", 8'h00, {7'h00, irq});
    wr(tmc_pkg::OFF_FLAGS, 8'h02);
    rd(tmc_pkg::OFF_FLAGS); cmp8("flags cleared", 8'h00, seen);
    for (int p = 0; p < 4; p++) begin
      wr(tmc_pkg::OFF_COUNT_HIGH, 8'h00);
      wr(tmc_pkg::OFF_COUNT_LOW, 8'h00);
      wr(tmc_pkg::OFF_CONTROL, 8'(p << 4) | 8'h01);
      repeat (32 << p) @(posedge clock_in);
      wr(tmc_pkg::OFF_CONTROL, 8'(p << 4));
      rd(tmc_pkg::OFF_COUNT_LOW); cmp_near("prescaled count", 8, seen);
      hold = seen;
      repeat (20) @(posedge clock_in);
      rd(tmc_pkg::OFF_COUNT_LOW); cmp8("held count", hold, seen);
    end
    wr(tmc_pkg::OFF_DIRECTION, 8'h00);
    // Third pass: oscillator system clock forces sync despite the disable bit
    for (int m = 0; m < 4; m++) begin
      @(posedge clock_in);
      use_osc <= (m == 3);
      from_osc <= (m == 2);
      wr(tmc_pkg::OFF_COMPANION, (m == 3) ? 8'h08 : 8'h00);
      wr(tmc_pkg::OFF_CONTROL, 8'h00);
      wr(tmc_pkg::OFF_COUNT_HIGH, 8'h00);
      wr(tmc_pkg::OFF_COUNT_LOW, 8'h00);
      wr(tmc_pkg::OFF_CONTROL, (m == 1 || m == 2) ? 8'h07 : 8'h03);
      burst(8'd5);
      rd(tmc_pkg::OFF_COUNT_LOW); cmp8("first burst", 8'h04, seen);
      burst(8'd3);
      rd(tmc_pkg::OFF_COUNT_LOW); cmp8("second burst", 8'h07, seen);
    end
    cmp8("pin enables osc", 8'h00, {6'h00, pin_oe});
    rd(tmc_pkg::OFF_PIN_LEVEL); cmp8("pin level osc", 8'h00, seen);
    wr(tmc_pkg::OFF_COMPANION, 8'h00);
    #1 cmp8("pin enables", 8'h03, {6'h00, pin_oe});
    rd(tmc_pkg::OFF_PIN_LEVEL); cmp8("pin level", {6'h00, pin_level}, seen);
    latch = 8'($urandom);
    wr(tmc_pkg::OFF_LATCH, latch);
    #1 cmp8("pin latch", {6'h00, latch[1:0]}, {6'h00, pin_out});
    for (int r = 0; r < 4; r++) begin
      rc = 2'(r);
      wr(tmc_pkg::OFF_CONTROL, {1'b0, rc[1], 2'b00, rc[0], 3'b000});
      #1 cmp8("timebase", {3'h0, route_tab[r]}, {3'h0, route});
    end
    wr(tmc_pkg::OFF_CONTROL, 8'h00);
    wr(tmc_pkg::OFF_COUNT_HIGH, 8'h12);
    wr(tmc_pkg::OFF_COUNT_LOW, 8'h34);
    trigger(4'($urandom % 11), 1'b0);
    rd(tmc_pkg::OFF_COUNT_LOW); cmp8("other mode", 8'h34, seen);
    trigger(tmc_pkg::COMPARE_SPECIAL_EVENT, 1'b0);
    rd(tmc_pkg::OFF_COUNT_HIGH); cmp8("cleared high", 8'h00, seen);
    rd(tmc_pkg::OFF_FLAGS); cmp8("no flag", 8'h00, seen);
    wr(tmc_pkg::OFF_COUNT_HIGH, 8'h12);
    trigger(tmc_pkg::COMPARE_SPECIAL_EVENT, 1'b1);
    rd(tmc_pkg::OFF_COUNT_LOW); cmp8("write wins", 8'h55, seen);
    rd(tmc_pkg::OFF_COUNT_HIGH); cmp8("other byte", 8'h12, seen);
    wr(tmc_pkg::OFF_CONTROL, 8'h80);
    wr(tmc_pkg::OFF_COUNT_HIGH, 8'hAB);
    rd(tmc_pkg::OFF_COUNT_HIGH); cmp8("buffer", 8'hAB, seen);
    rd(tmc_pkg::OFF_COUNT_LOW); cmp8("wide low", 8'h55, seen);
    rd(tmc_pkg::OFF_COUNT_HIGH); cmp8("latched high", 8'h12, seen);
    wr(tmc_pkg::OFF_COUNT_HIGH, 8'hAB);
    wr(tmc_pkg::OFF_COUNT_LOW, 8'hCD);
    wr(tmc_pkg::OFF_CONTROL, 8'h00);
    rd(tmc_pkg::OFF_COUNT_HIGH); cmp8("wide write high", 8'hAB, seen);
    rd(tmc_pkg::OFF_COUNT_LOW); cmp8("wide write low", 8'hCD, seen);
    print_verdict();
  end
endmodule

// ===== verification/tmc_ext_source.sv
`timescale 1ns/1ps
module tmc_ext_source (
  input  wire logic       clock_in,
  input  wire logic       start_in,
  input  wire logic [7:0] pulses_in,
  input  wire logic       use_osc_in,
  output logic            count_pin_out,
  output logic            osc_out,
  output logic            busy_out
);
  int   half_left = 0;
  int   phase     = 0;
  logic level     = 1'b0;

  // Six system clocks per half period, slow enough for the synchroniser
  always @(posedge clock_in) begin
    if (start_in) begin
      half_left <= 2 * int'(pulses_in);
      phase <= 0;
    end else if (half_left > 0) begin
      if (phase == 5) begin
        phase <= 0;
        half_left <= half_left - 1;
        level <= ~level;
      end else begin
        phase <= phase + 1;
      end
    end
  end

  // Stands low between bursts, so each later rise follows a fall
  assign count_pin_out = level & ~use_osc_in;
  assign osc_out       = level & use_osc_in;
  assign busy_out      = half_left > 0;
endmodule

// ===== verilog/tmc_pkg.sv
package tmc_pkg;
  // Register byte offsets on the plain register port
  localparam logic [3:0] OFF_CONTROL   = 4'h0;
  localparam logic [3:0] OFF_COUNT_LOW = 4'h1;
  localparam logic [3:0] OFF_COUNT_HIGH = 4'h2;
  localparam logic [3:0] OFF_FLAGS     = 4'h3;
  localparam logic [3:0] OFF_ENABLES   = 4'h4;
  localparam logic [3:0] OFF_COMPANION = 4'h5;
  localparam logic [3:0] OFF_DIRECTION = 4'h6;
  localparam logic [3:0] OFF_LATCH     = 4'h7;
  localparam logic [3:0] OFF_PIN_LEVEL = 4'h8;

  // Control register fields
  localparam int BIT_RUN        = 0;
  localparam int BIT_SOURCE     = 1;
  localparam int BIT_SYNC_OFF   = 2;
  localparam int BIT_ROUTE_LO   = 3;
  localparam int BIT_PRESC_LO   = 4;
  localparam int BIT_PRESC_HI   = 5;
  localparam int BIT_ROUTE_HI   = 6;
  localparam int BIT_WIDE       = 7;
  // Flag and enable registers share one layout
  localparam int BIT_OVERFLOW   = 1;
  // Companion timer control
  localparam int BIT_OSC_ENABLE = 3;

  // Reset values and count maximum
  localparam logic [7:0]  RESET_CONTROL   = 8'h00;
  localparam logic [7:0]  RESET_COMPANION = 8'h00;
  localparam logic [7:0]  RESET_DIRECTION = 8'hFF;
  localparam logic [7:0]  RESET_LATCH     = 8'h00;
  localparam logic [15:0] RESET_COUNT     = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hFFFF;

  // Compare mode code that fires the special event trigger
  localparam logic [3:0] COMPARE_SPECIAL_EVENT = 4'hB;

  // Capture unit routing, one bit per unit, 1 selects timers 3/4
  localparam logic [4:0] ROUTE_ALL_LOW   = 5'h00;
  localparam logic [4:0] ROUTE_FROM_TWO  = 5'h1E;
  localparam logic [4:0] ROUTE_FROM_THREE = 5'h1C;
  localparam logic [4:0] ROUTE_ALL_HIGH  = 5'h1F;

  // Instruction cycle is four oscillator periods
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int INSTR_PERIOD_NS = 80;
  localparam logic [1:0] INSTR_LAST =
    2'((INSTR_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS - 1);

  // Prescaler terminal counts for 1:1, 1:2, 1:4, 1:8
  localparam logic [2:0] PRESC_LAST_1 = 3'h0;
  localparam logic [2:0] PRESC_LAST_2 = 3'h1;
  localparam logic [2:0] PRESC_LAST_4 = 3'h3;
  localparam logic [2:0] PRESC_LAST_8 = 3'h7;
endpackage

// ===== verilog/tmc_sync2.sv
`timescale 1ns/1ps
module tmc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      stage_one <= '0;
      stage_two <= '0;
    end else begin
      stage_one <= async_in;
      stage_two <= stage_one;
    end
  end

  assign sync_out = stage_two;
endmodule

// ===== verilog/tmc_timer.sv
`timescale 1ns/1ps
// Behaviour
// (RULE1) Sixteen-bit count runs 0000h to FFFFh, then wraps to 0000h.
// (RULE2) Wrap sets the overflow flag; interrupt only when its enable is set. The code sets no flag when a low or high write lands in the wrap cycle.
// (RULE3) Source bit 0: count once per instruction cycle, a quarter of oscillator.
// (RULE4) Source bit 1: count external rising edges, first one after a falling edge.
// (RULE5) External source: sync bit 0 synchronises, 1 counts unsynchronised.
// (RULE6) Run bit set counts; cleared stops and holds the value.
// (RULE7) Prescale field divides input by 1, 2, 4 or 8.
// (RULE8) Wide access bit selects one 16-bit access or two byte accesses.
// (RULE9) Timebase field routes timers 1/2 or 3/4 to capture units 1 to 5.
// (RULE10) Special event trigger from the compare unit clears the count.
// (RULE11) Oscillator enabled forces both port pins to inputs reading 0.
// (RULE12) Companion control bit 3 enables the shared low-power oscillator.
// (RULE13) Sync bit not trusted when system clock comes from that oscillator.
// (RULE14) Clear happens when the compare mode code is 1011.
// (RULE15) A trigger clear never sets the overflow flag.
// (RULE16) A count write in the same cycle as a trigger clear wins.
// (RULE17) Wide mode: low read latches high; low write loads high from buffer.
// (RULE18) Prescaler cleared by low byte write and reset; control resets to 0.
module tmc_timer (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       write_in,
  input  wire logic       read_in,
  output logic      [7:0] rdata_out,
  input  wire logic       external_count_pin_in,
  input  wire logic       low_power_osc_in,
  input  wire logic [1:0] pin_level_in,
  input  wire logic       special_event_in,
  input  wire logic [3:0] compare_mode_code_in,
  input  wire logic       system_clock_from_osc_in,
  output logic      [1:0] pin_out,
  output logic      [1:0] pin_oe_out,
  output logic      [4:0] ccp_timebase_out,
  output logic            irq_out
);
  logic [7:0]  timer_three_control;
  logic [7:0]  companion_timer_control;
  logic [7:0]  port_c_direction;
  logic [7:0]  port_c_latch;
  logic [15:0] count;
  logic [7:0]  high_buffer;
  logic        overflow_flag;
  logic        overflow_irq_enable;
  logic [2:0]  presc;
  logic [1:0]  instr_cnt;
  logic        src_prev;
  logic        armed;
  logic        pending;
  logic [7:0]  rdata;

  logic [7:0]  next_timer_three_control;
  logic [7:0]  next_companion_timer_control;
  logic [7:0]  next_port_c_direction;
  logic [7:0]  next_port_c_latch;
  logic [15:0] next_count;
  logic [7:0]  next_high_buffer;
  logic        next_overflow_flag;
  logic        next_overflow_irq_enable;
  logic [2:0]  next_presc;
  logic [1:0]  next_instr_cnt;
  logic        next_src_prev;
  logic        next_armed;
  logic        next_pending;
  logic [7:0]  next_rdata;

  logic [3:0]  synced;
  logic        counter_run;
  logic        clock_source_select;
  logic        external_sync_disable;
  logic        wide_access_mode;
  logic [1:0]  prescale_field;
  logic [1:0]  capture_timebase_route;
  logic        low_power_osc_enable;
  logic        instr_en;
  logic        src;
  logic        rise;
  logic        fall;
  logic        sync_mode;
  logic        ext_raw;
  logic        ext_event;
  logic        in_event;
  logic [2:0]  presc_last;
  logic        presc_tick;
  logic        trigger_clear;
  logic        wr_low;
  logic        wr_high;
  logic        rd_low;
  logic        overflow;
  logic [1:0]  pin_read;

  // Pins and oscillator come from outside the clock domain
  tmc_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({pin_level_in, low_power_osc_in, external_count_pin_in}),
    .sync_out (synced)
  );

  assign counter_run            = timer_three_control[tmc_pkg::BIT_RUN];
  assign clock_source_select    = timer_three_control[tmc_pkg::BIT_SOURCE];
  assign external_sync_disable  = timer_three_control[tmc_pkg::BIT_SYNC_OFF];
  assign wide_access_mode       = timer_three_control[tmc_pkg::BIT_WIDE];
  assign prescale_field         = {timer_three_control[tmc_pkg::BIT_PRESC_HI],
                                   timer_three_control[tmc_pkg::BIT_PRESC_LO]};
  assign capture_timebase_route = {timer_three_control[tmc_pkg::BIT_ROUTE_HI],
                                   timer_three_control[tmc_pkg::BIT_ROUTE_LO]};
  assign low_power_osc_enable   = companion_timer_control[tmc_pkg::BIT_OSC_ENABLE]; // RULE12

  assign instr_en = (instr_cnt == tmc_pkg::INSTR_LAST); // RULE3
  assign src      = low_power_osc_enable ? synced[1] : synced[0]; // RULE4
  assign rise     = src & ~src_prev;
  assign fall     = ~src & src_prev;
  // An oscillator-driven system clock cannot skip its own sync stage
  assign sync_mode = ~external_sync_disable | system_clock_from_osc_in; // RULE5 RULE13
  assign ext_raw   = armed & rise; // RULE4
  assign ext_event = sync_mode ? (instr_en & (pending | ext_raw)) : ext_raw; // RULE5
  assign in_event  = clock_source_select ? ext_event : instr_en; // RULE3 RULE4

  always_comb begin
    unique case (prescale_field) // RULE7
      2'b00: presc_last = tmc_pkg::PRESC_LAST_1;
      2'b01: presc_last = tmc_pkg::PRESC_LAST_2;
      2'b10: presc_last = tmc_pkg::PRESC_LAST_4;
      2'b11: presc_last = tmc_pkg::PRESC_LAST_8;
    endcase
  end

  assign presc_tick = counter_run & in_event & (presc >= presc_last); // RULE6 RULE7
  assign trigger_clear = special_event_in &
                         (compare_mode_code_in == tmc_pkg::COMPARE_SPECIAL_EVENT); // RULE14
  assign wr_low  = write_in & (addr_in == tmc_pkg::OFF_COUNT_LOW);
  assign wr_high = write_in & (addr_in == tmc_pkg::OFF_COUNT_HIGH);
  assign rd_low  = read_in & (addr_in == tmc_pkg::OFF_COUNT_LOW);
  // Lost on any coinciding low or high write, even a wide-mode high write that only loads the buffer while the count wraps
  assign overflow = presc_tick & (count == tmc_pkg::COUNT_MAX) & ~wr_low & ~wr_high
                    & ~trigger_clear; // RULE2 RULE15
  assign pin_read = low_power_osc_enable ? 2'h0 : synced[3:2]; // RULE11

  always_comb begin
    next_timer_three_control     = timer_three_control;
    next_companion_timer_control = companion_timer_control;
    next_port_c_direction        = port_c_direction;
    next_port_c_latch            = port_c_latch;
    next_count                   = count;
    next_high_buffer             = high_buffer;
    next_overflow_irq_enable     = overflow_irq_enable;
    next_instr_cnt               = instr_en ? 2'h0 : instr_cnt + 2'h1;
    next_src_prev                = src;
    next_armed                   = clock_source_select & (armed | fall); // RULE4
    next_pending                 = clock_source_select & sync_mode & ~instr_en
                                   & (pending | ext_raw); // RULE5
    next_presc                   = presc;
    if (counter_run && in_event) begin
      next_presc = presc_tick ? 3'h0 : presc + 3'h1;
    end
    if (presc_tick) begin
      next_count = count + 16'h0001; // RULE1
    end
    if (trigger_clear) begin
      next_count = tmc_pkg::RESET_COUNT; // RULE10 RULE14
    end
    // Software write beats the trigger clear and the increment
    if (wr_low) begin
      next_count[7:0] = wdata_in; // RULE16
      next_presc      = 3'h0; // RULE18
      if (wide_access_mode) begin
        next_count[15:8] = high_buffer; // RULE17
      end else if (trigger_clear) begin
        next_count[15:8] = count[15:8]; // RULE16
      end
    end
    if (wr_high) begin
      if (wide_access_mode) begin
        next_high_buffer = wdata_in; // RULE17
      end else begin
        next_count[15:8] = wdata_in; // RULE8
        if (trigger_clear) begin
          next_count[7:0] = count[7:0]; // RULE16
        end
      end
    end
    if (rd_low && wide_access_mode) begin
      next_high_buffer = count[15:8]; // RULE17
    end
    if (write_in) begin
      unique case (addr_in)
        tmc_pkg::OFF_CONTROL:   next_timer_three_control = wdata_in;
        tmc_pkg::OFF_ENABLES:   next_overflow_irq_enable = wdata_in[tmc_pkg::BIT_OVERFLOW];
        tmc_pkg::OFF_COMPANION: next_companion_timer_control = wdata_in;
        tmc_pkg::OFF_DIRECTION: next_port_c_direction = wdata_in;
        tmc_pkg::OFF_LATCH:     next_port_c_latch = wdata_in;
        default: ;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    next_overflow_flag = (overflow_flag &
                          ~(write_in & (addr_in == tmc_pkg::OFF_FLAGS)
                            & wdata_in[tmc_pkg::BIT_OVERFLOW])) | overflow; // RULE2
    next_rdata = 8'h00;
    if (read_in) begin
      unique case (addr_in)
        tmc_pkg::OFF_CONTROL:    next_rdata = timer_three_control;
        tmc_pkg::OFF_COUNT_LOW:  next_rdata = count[7:0];
        tmc_pkg::OFF_COUNT_HIGH: next_rdata = wide_access_mode ? high_buffer
                                                               : count[15:8]; // RULE8 RULE17
        tmc_pkg::OFF_FLAGS:      next_rdata = {6'h00, overflow_flag, 1'b0};
        tmc_pkg::OFF_ENABLES:    next_rdata = {6'h00, overflow_irq_enable, 1'b0};
        tmc_pkg::OFF_COMPANION:  next_rdata = companion_timer_control;
        tmc_pkg::OFF_DIRECTION:  next_rdata = port_c_direction;
        tmc_pkg::OFF_LATCH:      next_rdata = port_c_latch;
        tmc_pkg::OFF_PIN_LEVEL:  next_rdata = {6'h00, pin_read};
        default:                 next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      timer_three_control     <= tmc_pkg::RESET_CONTROL; // RULE18
      companion_timer_control <= tmc_pkg::RESET_COMPANION;
      port_c_direction        <= tmc_pkg::RESET_DIRECTION;
      port_c_latch            <= tmc_pkg::RESET_LATCH;
      count                   <= tmc_pkg::RESET_COUNT;
      high_buffer             <= 8'h00;
      overflow_flag           <= 1'b0;
      overflow_irq_enable     <= 1'b0;
      presc                   <= 3'h0; // RULE18
      instr_cnt               <= 2'h0;
      src_prev                <= 1'b0;
      armed                   <= 1'b0;
      pending                 <= 1'b0;
      rdata                   <= 8'h00;
    end else begin
      timer_three_control     <= next_timer_three_control;
      companion_timer_control <= next_companion_timer_control;
      port_c_direction        <= next_port_c_direction;
      port_c_latch            <= next_port_c_latch;
      count                   <= next_count;
      high_buffer             <= next_high_buffer;
      overflow_flag           <= next_overflow_flag;
      overflow_irq_enable     <= next_overflow_irq_enable;
      presc                   <= next_presc;
      instr_cnt               <= next_instr_cnt;
      src_prev                <= next_src_prev;
      armed                   <= next_armed;
      pending                 <= next_pending;
      rdata                   <= next_rdata;
    end
  end

  always_comb begin
    unique case (capture_timebase_route) // RULE9
      2'b00: ccp_timebase_out = tmc_pkg::ROUTE_ALL_LOW;
      2'b01: ccp_timebase_out = tmc_pkg::ROUTE_FROM_TWO;
      2'b10: ccp_timebase_out = tmc_pkg::ROUTE_FROM_THREE;
      2'b11: ccp_timebase_out = tmc_pkg::ROUTE_ALL_HIGH;
    endcase
  end

  assign rdata_out  = rdata;
  assign irq_out    = overflow_flag & overflow_irq_enable; // RULE2
  assign pin_out    = port_c_latch[1:0];
  // Direction bit 1 means input; the oscillator overrides it
  assign pin_oe_out = ~port_c_direction[1:0] & {2{~low_power_osc_enable}}; // RULE11

  property p_wrap;
    @(posedge clock_in) disable iff (reset_in)
      overflow |=> (count == 16'h0000) && overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to zero"); // RULE1

  property p_irq;
    @(posedge clock_in) disable iff (reset_in)
      irq_out == (overflow_flag && overflow_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not gated by enable"); // RULE2

  property p_hold;
    @(posedge clock_in) disable iff (reset_in)
      (!counter_run && !write_in && !trigger_clear) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved"); // RULE6

  property p_instr_rate;
    @(posedge clock_in) disable iff (reset_in)
      instr_en |=> !instr_en [*3] ##1 instr_en;
  endproperty
  a_instr_rate: assert property (p_instr_rate) else $error("instruction rate wrong"); // RULE3

  property p_clear;
    @(posedge clock_in) disable iff (reset_in)
      (trigger_clear && !write_in) |=> (count == 16'h0000) && !$rose(overflow_flag);
  endproperty
  a_clear: assert property (p_clear) else $error("trigger clear wrong"); // RULE10 RULE15

  property p_write_wins;
    @(posedge clock_in) disable iff (reset_in)
      (trigger_clear && wr_low && !wide_access_mode) |=> count[7:0] == $past(wdata_in);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to clear"); // RULE16

  property p_wide_load;
    @(posedge clock_in) disable iff (reset_in)
      (wr_low && wide_access_mode) |=> count == {$past(high_buffer), $past(wdata_in)};
  endproperty
  a_wide_load: assert property (p_wide_load) else $error("wide write not atomic"); // RULE17

  property p_presc_clear;
    @(posedge clock_in) disable iff (reset_in)
      wr_low |=> presc == 3'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared"); // RULE18

  property p_osc_pins;
    @(posedge clock_in) disable iff (reset_in)
      low_power_osc_enable |-> (pin_oe_out == 2'h0) && (pin_read == 2'h0);
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("oscillator pins driven"); // RULE11
endmodule
